// [design/tkeis_core.sv]
// Contract
// [R01] Hold-recalibration enabled: recalibrate a key held for the hold time.
// [R02] Repeat select 0 gives one interrupt; 1 repeats while keys held.
// [R03] Interrupt function off bit 1 blocks the interrupt pin entirely.
// [R04] Fifteen read-only event flags set on press or release.
// [R05] Per-key interrupt enables, all reset to enabled.
// [R06] Per-key channel sense enables, all reset to enabled.
// [R07] Multi-touch enabled limits simultaneous keys to one, two or three.
// [R08] Without auto-release, interrupt stays low until both flag reads.
// [R09] Auto-release frees the interrupt after 10 to 200 ms.
// [R10] Second repeat interrupt one first-repeat delay after the first.
// [R11] Further interrupts one repeat period apart until release.
// [R12] Auto-sleep after idle time; divider is two to the code.
// [R13] Per-key wake enables reset zero; set key wakes from sleep.
// [R14] Gain code n scales count by n plus one into delta count.
// [R15] Hold time code 0 is 0.5 s, else that many seconds.
// [R16] Host reaches all registers by addressed byte reads and writes.
`include "tkeis_defs.svh"
`default_nettype none
module tkeis_core
  import tkeis_pkg::*;
#(
  parameter int KEYS = 15,
  parameter int COUNT_W = 12,
  parameter int TICK_CYC = `TKEIS_TICK_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire tkeis_req_t req,
  output logic [7:0] rdata,
  input wire logic [KEYS-1:0] key_touch_pin,
  input wire logic [COUNT_W-1:0] raw_count,
  input wire logic [3:0] raw_key,
  input wire logic raw_valid,
  output logic interrupt_output_n,
  output logic [KEYS-1:0] key_sense_on,
  output logic [KEYS-1:0] recal_pulse,
  output logic [COUNT_W+3:0] key_delta_count,
  output logic [3:0] key_delta_index,
  output logic key_delta_valid,
  output logic sleep_active,
  output logic [7:0] sleep_clock_divider
);
  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic [7:0] int_cfg, irq_lo, chen_lo, multi, arel, rpt, slp, wake_lo, gain;
  logic [6:0] irq_hi, chen_hi, wake_hi;
  logic [KEYS-1:0] key_event_flags, next_flags;
  logic [KEYS-1:0] key_irq_enable, channel_sense_enable, sleep_wake_key_enable;
  logic rd_lo_seen, rd_hi_seen, next_rd_lo_seen, next_rd_hi_seen;
  assign key_irq_enable = {irq_hi, irq_lo};
  assign channel_sense_enable = {chen_hi, chen_lo};
  assign sleep_wake_key_enable = {wake_hi, wake_lo};
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      int_cfg <= 8'h00;
      irq_lo <= `TKEIS_RST_EN_LO; // R05
      irq_hi <= `TKEIS_RST_EN_HI; // R05
      chen_lo <= `TKEIS_RST_EN_LO; // R06
      chen_hi <= `TKEIS_RST_EN_HI; // R06
      multi <= 8'h00;
      arel <= 8'h00;
      rpt <= 8'h00;
      slp <= 8'h00;
      wake_lo <= 8'h00; // R13
      wake_hi <= 7'h00; // R13
      gain <= 8'h00;
    end else if (req.wr) begin
      case (req.addr) // R16
        `TKEIS_OFS_INT_CFG: int_cfg <= req.wdata;
        `TKEIS_OFS_IRQEN_LO: irq_lo <= req.wdata;
        `TKEIS_OFS_IRQEN_HI: irq_hi <= req.wdata[6:0];
        `TKEIS_OFS_CHEN_LO: chen_lo <= req.wdata;
        `TKEIS_OFS_CHEN_HI: chen_hi <= req.wdata[6:0];
        `TKEIS_OFS_MULTI: multi <= req.wdata;
        `TKEIS_OFS_AUTOREL: arel <= req.wdata;
        `TKEIS_OFS_REPEAT: rpt <= req.wdata;
        `TKEIS_OFS_SLEEP: slp <= req.wdata;
        `TKEIS_OFS_WAKE_LO: wake_lo <= req.wdata;
        `TKEIS_OFS_WAKE_HI: wake_hi <= req.wdata[6:0];
        `TKEIS_OFS_GAIN: gain <= req.wdata;
        default: ;
      endcase
    end
  end
  // Read mux; unmapped offsets return zero
  logic [7:0] next_rdata;
  always_comb begin
    case (req.addr) // R16
      `TKEIS_OFS_INT_CFG: next_rdata = int_cfg;
      `TKEIS_OFS_FLAGS_LO: next_rdata = key_event_flags[7:0];
      `TKEIS_OFS_FLAGS_HI: next_rdata = {1'b0, key_event_flags[14:8]};
      `TKEIS_OFS_IRQEN_LO: next_rdata = irq_lo;
      `TKEIS_OFS_IRQEN_HI: next_rdata = {1'b0, irq_hi};
      `TKEIS_OFS_CHEN_LO: next_rdata = chen_lo;
      `TKEIS_OFS_CHEN_HI: next_rdata = {1'b0, chen_hi};
      `TKEIS_OFS_MULTI: next_rdata = multi;
      `TKEIS_OFS_AUTOREL: next_rdata = arel;
      `TKEIS_OFS_REPEAT: next_rdata = rpt;
      `TKEIS_OFS_SLEEP: next_rdata = slp;
      `TKEIS_OFS_WAKE_LO: next_rdata = wake_lo;
      `TKEIS_OFS_WAKE_HI: next_rdata = {1'b0, wake_hi};
      `TKEIS_OFS_GAIN: next_rdata = gain;
      default: next_rdata = 8'h00;
    endcase
  end
  // ----------------------------------------
  // Key pin synchroniser and multi-touch gate
  // ----------------------------------------
  logic [KEYS-1:0] s1, s2, s3, pressed, next_pressed;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= key_touch_pin;
      s2 <= s1;
      s3 <= s2;
    end
  end
  function automatic logic [2:0] ones(input logic [KEYS-1:0] v);
    logic [2:0] n;
    n = 3'h0;
    for (int i = 0; i < KEYS; i++) begin
      if (v[i] && n != 3'h7) n = n + 3'h1;
    end
    return n;
  endfunction
  // A key changes only when two stages agree; new presses beyond the
  // limit are refused so earlier keys keep priority
  always_comb begin
    next_pressed = pressed;
    for (int i = 0; i < KEYS; i++) begin
      if (s2[i] == s3[i]) begin
        if (!channel_sense_enable[i] || !s3[i]) begin // R06
          next_pressed[i] = 1'b0;
        end else if (!pressed[i]) begin
          if (!multi[`TKEIS_B_MULTI_EN] ||
              ones(next_pressed) < {1'b0, multi[1:0]}) begin // R07
            next_pressed[i] = 1'b1;
          end
        end
      end
    end
  end
  logic [KEYS-1:0] key_change;
  assign key_change = pressed ^ next_pressed;
  // ----------------------------------------
  // Event flags and read-clear
  // ----------------------------------------
  logic rd_lo, rd_hi, both_read;
  assign rd_lo = req.rd && req.addr == `TKEIS_OFS_FLAGS_LO;
  assign rd_hi = req.rd && req.addr == `TKEIS_OFS_FLAGS_HI;
  assign both_read = (rd_lo || rd_lo_seen) && (rd_hi || rd_hi_seen);

  always_comb begin
    next_flags = key_event_flags;
    next_rd_lo_seen = rd_lo_seen || rd_lo;
    next_rd_hi_seen = rd_hi_seen || rd_hi;
    if (both_read) begin // R08
      next_flags = '0;
      next_rd_lo_seen = 1'b0;
      next_rd_hi_seen = 1'b0;
    end
    next_flags = next_flags | key_change; // R04
  end

  // ----------------------------------------
  // Time base and interrupt sequencing
  // ----------------------------------------
  localparam int PRE_W = $clog2(TICK_CYC);
  logic [PRE_W-1:0] pre;
  logic tick;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) pre <= '0;
    else if (tick) pre <= '0;
    else pre <= pre + 1'b1;
  end
  assign tick = (pre == PRE_W'(TICK_CYC - 1));
  function automatic logic [7:0] rpt_ticks(input logic [3:0] c);
    if (c <= `TKEIS_CODE_500MS) return 8'(c * `TKEIS_STEP_50MS);
    return 8'(`TKEIS_STEP_500MS +
              (c - `TKEIS_CODE_500MS) * `TKEIS_STEP_100MS);
  endfunction
  // Long codes step by 50 ms, starting at 100 ms
  function automatic logic [7:0] arel_ticks(input logic [2:0] c);
    if (c <= 3'h4) return 8'({5'h0, c} + 8'h01);
    return 8'(`TKEIS_STEP_50MS * ({5'h0, c} - 8'h03));
  endfunction
  tkeis_irq_state_t st, next_st;
  logic [7:0] itimer, next_itimer, atimer, next_atimer;
  logic irq_line, next_irq_line;
  logic [KEYS-1:0] irq_evt;
  logic new_evt, repeat_on;
  assign irq_evt = key_change & key_irq_enable;
  assign new_evt = |irq_evt;
  assign repeat_on = int_cfg[`TKEIS_B_REPEAT] && |(pressed & key_irq_enable);
  always_comb begin
    next_st = st;
    next_itimer = itimer;
    next_atimer = atimer;
    next_irq_line = irq_line;
    if (both_read) next_irq_line = 1'b0; // R08
    if (irq_line && arel[`TKEIS_B_AREL_EN] && tick) begin
      if (atimer == 8'h01) next_irq_line = 1'b0; // R09
      next_atimer = atimer - 8'h01;
    end
    case (st)
      TKEIS_IDLE: ;
      TKEIS_FIRST: next_itimer = rpt_ticks(rpt[3:0]); // R10
      TKEIS_SECOND, TKEIS_REPEAT: begin
        if (tick && itimer != 8'h00) next_itimer = itimer - 8'h01;
      end
      default: next_st = TKEIS_IDLE;
    endcase
    if (st == TKEIS_FIRST) next_st = TKEIS_SECOND;
    if ((st == TKEIS_SECOND || st == TKEIS_REPEAT) &&
        tick && itimer == 8'h01) begin
      next_irq_line = 1'b1; // R11
      next_atimer = arel_ticks(arel[2:0]);
      next_st = TKEIS_REPEAT;
      next_itimer = rpt_ticks(rpt[7:4]); // R11
    end
    if ((st == TKEIS_SECOND && rpt[3:0] == 4'h0) ||
        (st == TKEIS_REPEAT && rpt[7:4] == 4'h0) || !repeat_on) begin
      if (st != TKEIS_FIRST) next_st = TKEIS_IDLE; // R02
    end
    if (new_evt) begin
      next_irq_line = 1'b1; // R02
      next_atimer = arel_ticks(arel[2:0]); // R09
      next_st = int_cfg[`TKEIS_B_REPEAT] ? TKEIS_FIRST : TKEIS_IDLE;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pressed <= '0;
      key_event_flags <= '0;
      rd_lo_seen <= 1'b0;
      rd_hi_seen <= 1'b0;
      st <= TKEIS_IDLE;
      itimer <= 8'h00;
      atimer <= 8'h00;
      irq_line <= 1'b0;
      interrupt_output_n <= 1'b1;
      rdata <= 8'h00;
      key_sense_on <= '1;
    end else begin
      pressed <= next_pressed;
      key_event_flags <= next_flags;
      rd_lo_seen <= next_rd_lo_seen;
      rd_hi_seen <= next_rd_hi_seen;
      st <= next_st;
      itimer <= next_itimer;
      atimer <= next_atimer;
      irq_line <= next_irq_line;
      interrupt_output_n <= !(next_irq_line &&
                              !int_cfg[`TKEIS_B_IRQ_OFF]); // R03
      rdata <= next_rdata;
      key_sense_on <= channel_sense_enable & {KEYS{!sleep_active}}; // R06
    end
  end

  // ----------------------------------------
  // Hold recalibration
  // ----------------------------------------
  logic [10:0] hold_limit;
  assign hold_limit = (gain[3:0] == 4'h0) ? `TKEIS_HALF_S :
                      11'(gain[3:0] * `TKEIS_ONE_S); // R15
  for (genvar g = 0; g < KEYS; g++) begin : g_hold
    tkeis_key_timer #(.LIMIT_W(11)) u_timer (
      .clk(clk),
      .rst_n(rst_n),
      .tick(tick),
      .hold(pressed[g]),
      .arm(int_cfg[`TKEIS_B_HOLD_EN]), // R01
      .limit(hold_limit),
      .expired(recal_pulse[g])
    );
  end

  // ----------------------------------------
  // Gain scaling
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      key_delta_count <= '0;
      key_delta_index <= 4'h0;
      key_delta_valid <= 1'b0;
    end else begin
      key_delta_valid <= raw_valid;
      if (raw_valid) begin
        key_delta_index <= raw_key;
        key_delta_count <= (COUNT_W+4)'(raw_count *
                           ({1'b0, gain[7:4]} + 5'h01)); // R14
      end
    end
  end

  // ----------------------------------------
  // Auto-sleep
  // ----------------------------------------
  logic [10:0] idle, next_idle, sleep_limit;
  logic next_sleep;
  logic [3:0] ast;
  assign ast = slp[3:0];
  assign sleep_limit = (ast <= `TKEIS_SLEEP_LIN) ?
    11'(({7'h0, ast} + 11'h1) * `TKEIS_HALF_S) :
    11'(({7'h0, ast} - 11'h4) * `TKEIS_ONE_S); // R12
  always_comb begin
    next_idle = idle;
    next_sleep = sleep_active;
    if (req.wr || req.rd || |key_change || !slp[`TKEIS_B_SLEEP_EN]) begin
      next_idle = 11'h0;
    end else if (tick && idle != sleep_limit) begin
      next_idle = idle + 11'h1;
    end
    if (slp[`TKEIS_B_SLEEP_EN] && tick && idle + 11'h1 == sleep_limit)
      next_sleep = 1'b1; // R12
    if (req.wr || req.rd || |(s3 & sleep_wake_key_enable)) begin
      next_sleep = 1'b0; // R13
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idle <= 11'h0;
      sleep_active <= 1'b0;
      sleep_clock_divider <= 8'h01;
    end else begin
      idle <= next_idle;
      sleep_active <= next_sleep;
      sleep_clock_divider <= 8'h01 << slp[6:4]; // R12
    end
  end
endmodule
`default_nettype wire

// [design/tkeis_defs.svh]
`ifndef TKEIS_DEFS_SVH
`define TKEIS_DEFS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define TKEIS_OFS_INT_CFG 8'h01
`define TKEIS_OFS_FLAGS_LO 8'h02
`define TKEIS_OFS_FLAGS_HI 8'h03
`define TKEIS_OFS_IRQEN_LO 8'h04
`define TKEIS_OFS_IRQEN_HI 8'h05
`define TKEIS_OFS_CHEN_LO 8'h06
`define TKEIS_OFS_CHEN_HI 8'h07
`define TKEIS_OFS_MULTI 8'h08
`define TKEIS_OFS_AUTOREL 8'h09
`define TKEIS_OFS_REPEAT 8'h0a
`define TKEIS_OFS_SLEEP 8'h0b
`define TKEIS_OFS_WAKE_LO 8'h0c
`define TKEIS_OFS_WAKE_HI 8'h0d
`define TKEIS_OFS_GAIN 8'h0e
// ----------------------------------------
// Reset values
// ----------------------------------------
`define TKEIS_RST_EN_LO 8'hff
`define TKEIS_RST_EN_HI 7'h7f
// ----------------------------------------
// Field positions
// ----------------------------------------
`define TKEIS_B_HOLD_EN 3
`define TKEIS_B_REPEAT 2
`define TKEIS_B_IRQ_OFF 1
`define TKEIS_B_MULTI_EN 2
`define TKEIS_B_AREL_EN 3
`define TKEIS_B_SLEEP_EN 7
// ----------------------------------------
// Timing: one tick is 10 ms
// ----------------------------------------
`define TKEIS_CLK_HZ 100000000
`define TKEIS_TICK_MS 10
`define TKEIS_TICK_CYC (`TKEIS_CLK_HZ / 1000 * `TKEIS_TICK_MS)
`define TKEIS_STEP_50MS 8'h05
`define TKEIS_STEP_100MS 8'h0a
`define TKEIS_STEP_500MS 8'h32
`define TKEIS_HALF_S 11'h032
`define TKEIS_ONE_S 11'h064
`define TKEIS_CODE_500MS 4'ha
`define TKEIS_SLEEP_LIN 4'h9
`endif

// [design/tkeis_key_timer.sv]
`include "tkeis_defs.svh"
`default_nettype none
module tkeis_key_timer
  import tkeis_pkg::*;
#(
  parameter int LIMIT_W = 11
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic hold,
  input wire logic arm,
  input wire logic [LIMIT_W-1:0] limit,
  output logic expired
);
  logic [LIMIT_W-1:0] count;
  logic [LIMIT_W-1:0] next_count;
  logic next_expired;

  // Counts ticks while held, fires once per hold
  always_comb begin
    next_count = count;
    next_expired = 1'b0;
    if (!hold || !arm) begin
      next_count = '0;
    end else if (tick && count != limit) begin
      next_count = count + 1'b1;
      next_expired = (count + 1'b1 == limit);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
      expired <= 1'b0;
    end else begin
      count <= next_count;
      expired <= next_expired;
    end
  end
endmodule
`default_nettype wire

// [design/tkeis_pkg.sv]
`default_nettype none
package tkeis_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tkeis_req_t;
  typedef enum logic [1:0] {
    TKEIS_IDLE, TKEIS_FIRST, TKEIS_SECOND, TKEIS_REPEAT
  } tkeis_irq_state_t;
endpackage
`default_nettype wire

// [tb/tkeis_core_test.sv]
`default_nettype none
module tkeis_core_test
  import tkeis_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  tkeis_req_t req;
  logic [7:0] rdata, divider;
  logic [14:0] keys = '0, sense_on, recal;
  logic [11:0] raw_count = 12'h000;
  logic [3:0] raw_key = 4'h0, delta_index;
  logic raw_valid = 1'b0, irq_n, delta_valid, asleep;
  logic [15:0] delta_count;
  int num_errors = 0, total_checks = 0;
  always #5 clk = ~clk;
  tkeis_core #(.TICK_CYC(10)) u_tkeis_core (.clk(clk), .rst_n(rst_n),
    .req(req), .rdata(rdata), .key_touch_pin(keys), .raw_count(raw_count),
    .raw_key(raw_key), .raw_valid(raw_valid), .interrupt_output_n(irq_n),
    .key_sense_on(sense_on), .recal_pulse(recal),
    .key_delta_count(delta_count), .key_delta_index(delta_index),
    .key_delta_valid(delta_valid), .sleep_active(asleep),
    .sleep_clock_divider(divider));
  tkeis_host u_tkeis_host (.clk(clk), .rdata(rdata), .req(req));
  // ----------------------------------------
  // Shared helpers
  // ----------------------------------------
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic set_keys(input logic [14:0] v);
    @(posedge clk);
    keys <= v;
  endtask
  task automatic wait_irq(input logic lvl, input int max, output int n);
    n = 0;
    while (irq_n !== lvl && n < max) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    logic [7:0] exp [13] = '{8'h00, 8'h00, 8'hff, 8'h7f, 8'hff, 8'h7f,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] d;
    for (int i = 0; i < 13; i++) begin
      u_tkeis_host.rd(8'h02 + 8'(i), d);
      check("reset value", d, exp[i]);
    end
    u_tkeis_host.wr(8'h02, 8'h5a);
    u_tkeis_host.rd(8'h02, d);
    check("written flags", d, 8'h00);
    u_tkeis_host.wr(8'h0d, 8'hff);
    u_tkeis_host.rd(8'h0d, d);
    check("wake high", d, 8'h7f);
    u_tkeis_host.wr(8'h04, 8'h3c);
    u_tkeis_host.rd(8'h04, d);
    check("irq enable", d, 8'h3c);
    u_tkeis_host.rd(8'h40, d);
    check("unmapped", d, 8'h00);
    u_tkeis_host.wr(8'h04, 8'hff);
    u_tkeis_host.wr(8'h0d, 8'h00);
    u_tkeis_host.wr(8'h07, 8'h00);
    @(posedge clk);
    #1 check("sense enable", sense_on, 16'h00ff);
    u_tkeis_host.wr(8'h07, 8'h7f);
  endtask
  task automatic t_multi();
    logic [7:0] d;
    u_tkeis_host.wr(8'h08, 8'h05);
    set_keys(15'h0003);
    repeat (10) @(posedge clk);
    u_tkeis_host.rd(8'h02, d);
    check("one key limit", d, 8'h01);
    set_keys(15'h0000);
    repeat (10) @(posedge clk);
    u_tkeis_host.ack();
    u_tkeis_host.wr(8'h08, 8'h00);
  endtask
  task automatic t_irq();
    int n;
    logic [7:0] d;
    set_keys(15'h0200);
    wait_irq(1'b0, 30, n);
    check("irq on press", irq_n, 1'b0);
    u_tkeis_host.rd(8'h02, d);
    check("irq after one read", irq_n, 1'b0);
    u_tkeis_host.rd(8'h03, d);
    check("high flags", d, 8'h02);
    wait_irq(1'b1, 3, n);
    check("irq after both reads", irq_n, 1'b1);
    set_keys(15'h0000);
    wait_irq(1'b0, 30, n);
    u_tkeis_host.ack();
    u_tkeis_host.wr(8'h04, 8'hfe);
    set_keys(15'h0001);
    wait_irq(1'b0, 30, n);
    check("masked key irq", irq_n, 1'b1);
    u_tkeis_host.rd(8'h02, d);
    check("masked key flag", d, 8'h01);
    u_tkeis_host.wr(8'h01, 8'h02);
    set_keys(15'h0002);
    wait_irq(1'b0, 30, n);
    check("irq function off", irq_n, 1'b1);
    set_keys(15'h0000);
    repeat (10) @(posedge clk);
    u_tkeis_host.ack();
    u_tkeis_host.wr(8'h04, 8'hff);
    u_tkeis_host.wr(8'h01, 8'h00);
  endtask
  task automatic t_autorel();
    int tk [8] = '{1, 2, 3, 4, 5, 10, 15, 20};
    int n;
    for (int c = 0; c < 8; c++) begin
      u_tkeis_host.wr(8'h09, 8'h08 | 8'(c));
      set_keys(15'h0004);
      wait_irq(1'b0, 30, n);
      wait_irq(1'b1, 300, n);
      n = n - tk[c] * 10;
      check("release time", n >= -11 && n <= 3, 1'b1);
      set_keys(15'h0000);
      wait_irq(1'b0, 30, n);
      wait_irq(1'b1, 300, n);
      u_tkeis_host.ack();
    end
  endtask
  task automatic t_repeat();
    int n, a, b;
    u_tkeis_host.wr(8'h01, 8'h04);
    u_tkeis_host.wr(8'h09, 8'h08);
    u_tkeis_host.wr(8'h0a, 8'h21);
    set_keys(15'h0018);
    wait_irq(1'b0, 30, n);
    for (int i = 0; i < 2; i++) begin
      wait_irq(1'b1, 30, a);
      wait_irq(1'b0, 150, b);
      n = i == 0 ? 50 : 100;
      check("repeat gap", a + b >= n - 10 && a + b <= n + 10, 1'b1);
    end
    set_keys(15'h0000);
    wait_irq(1'b1, 30, n);
    wait_irq(1'b0, 30, n);
    wait_irq(1'b1, 30, n);
    u_tkeis_host.wr(8'h01, 8'h00);
    u_tkeis_host.ack();
    set_keys(15'h0020);
    wait_irq(1'b0, 30, n);
    wait_irq(1'b1, 30, n);
    wait_irq(1'b0, 150, n);
    check("single irq mode", irq_n, 1'b1);
    set_keys(15'h0000);
    repeat (30) @(posedge clk);
    u_tkeis_host.ack();
    u_tkeis_host.wr(8'h09, 8'h00);
  endtask
  task automatic t_gain();
    for (int g = 0; g < 16; g += 5) begin
      u_tkeis_host.wr(8'h0e, 8'(g << 4));
      @(posedge clk);
      raw_count <= 12'h9c3;
      raw_key <= 4'(g);
      raw_valid <= 1'b1;
      @(posedge clk);
      raw_valid <= 1'b0;
      #1 check("delta count", delta_count, 16'h09c3 * 16'(g + 1));
      check("delta valid", delta_valid, 1'b1);
      check("delta index", {12'h000, delta_index}, 16'(g));
    end
    u_tkeis_host.wr(8'h0e, 8'h00);
  endtask
  task automatic t_recal();
    int n = 0;
    u_tkeis_host.wr(8'h01, 8'h08);
    set_keys(15'h0040);
    while (recal[6] !== 1'b1 && n < 700) begin
      @(posedge clk);
      #1 n++;
    end
    check("hold recal time", n >= 485 && n <= 515, 1'b1);
    set_keys(15'h0000);
    repeat (20) @(posedge clk);
    u_tkeis_host.ack();
    u_tkeis_host.wr(8'h01, 8'h00);
  endtask
  task automatic t_sleep();
    int n = 0;
    u_tkeis_host.wr(8'h0c, 8'h04);
    u_tkeis_host.wr(8'h0b, 8'hb0);
    while (asleep !== 1'b1 && n < 700) begin
      @(posedge clk);
      #1 n++;
    end
    check("idle sleep time", n >= 480 && n <= 515, 1'b1);
    check("sleep divider", divider, 8'h08);
    @(posedge clk);
    #1 check("sense in sleep", sense_on, 15'h0000);
    set_keys(15'h0080);
    repeat (30) @(posedge clk);
    check("wake by masked key", asleep, 1'b1);
    set_keys(15'h0084);
    repeat (10) @(posedge clk);
    check("wake by enabled key", asleep, 1'b0);
    set_keys(15'h0000);
    u_tkeis_host.wr(8'h0b, 8'h00);
    u_tkeis_host.ack();
  endtask
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_irq();
    t_multi();
    t_autorel();
    t_repeat();
    t_gain();
    t_recal();
    t_sleep();
    conclude();
  end
  // Whole run needs about 3000 cycles
  initial begin
    repeat (30000) @(posedge clk);
    num_errors++;
    conclude();
  end
endmodule
`default_nettype wire

// [tb/tkeis_host.sv]
`default_nettype none
module tkeis_host
  import tkeis_pkg::*;
(
  input wire logic clk,
  input wire logic [7:0] rdata,
  output var tkeis_req_t req
);
  timeunit 1ns;
  timeprecision 1ns;
  initial req = '0;
  // Addressed byte write, strobe held one edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Both status reads acknowledge the interrupt
  task automatic ack();
    logic [7:0] d;
    rd(8'h02, d);
    rd(8'h03, d);
  endtask
endmodule
`default_nettype wire

// [tb/tkeis_monitor.sv]
`default_nettype none
module tkeis_monitor
  import tkeis_pkg::*;
#(
  parameter int KEYS = 15,
  parameter int COUNT_W = 12,
  parameter int TICK_CYC = 10
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire tkeis_req_t req,
  input wire logic [7:0] rdata,
  input wire logic [COUNT_W-1:0] raw_count,
  input wire logic raw_valid,
  input wire logic interrupt_output_n,
  input wire logic [KEYS-1:0] key_sense_on,
  input wire logic [KEYS-1:0] recal_pulse,
  input wire logic [COUNT_W+3:0] key_delta_count,
  input wire logic key_delta_valid,
  input wire logic sleep_active,
  input wire logic [7:0] sleep_clock_divider
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // Shadow of written configuration
  // ----------------------------------------
  logic [7:0] cfg, arel, slp, gain;
  logic [KEYS-1:0] chen;
  logic [COUNT_W+3:0] scaled;
  int low_cnt;
  assign scaled = raw_count * (gain[7:4] + 5'h01);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= 8'h00;
      arel <= 8'h00;
      slp <= 8'h00;
      gain <= 8'h00;
      chen <= '1;
      low_cnt <= 0;
    end else begin
      low_cnt <= interrupt_output_n ? 0 : low_cnt + 1;
      if (req.wr) begin
        case (req.addr)
          8'h01: cfg <= req.wdata;
          8'h06: chen[7:0] <= req.wdata;
          8'h07: chen[KEYS-1:8] <= req.wdata[KEYS-9:0];
          8'h09: arel <= req.wdata;
          8'h0b: slp <= req.wdata;
          8'h0e: gain <= req.wdata;
          default: ;
        endcase
      end
    end
  end
  sequence s_write(logic [7:0] a);
    req.wr && req.addr == a;
  endsequence
  sequence s_idle_at(logic [7:0] a);
    !req.wr && req.addr == a;
  endsequence
  a_reg_readback: assert property (
    s_write(8'h04) ##1 s_idle_at(8'h04) |=> rdata == $past(req.wdata, 2))
    else $error("register readback differs from write");
  a_unmapped_zero: assert property (
    req.addr == 8'h40 |=> rdata == 8'h00)
    else $error("unmapped address read nonzero");
  a_irq_off_high: assert property (
    cfg[1] [*3] |-> interrupt_output_n)
    else $error("interrupt pin low while function off");
  a_recal_off: assert property (
    !cfg[3] [*2] |-> recal_pulse == '0)
    else $error("recalibration while hold disabled");
  a_gain_scale: assert property (
    raw_valid |=> key_delta_valid && key_delta_count == $past(scaled))
    else $error("delta count not scaled by gain");
  a_divider_code: assert property (
    s_write(8'h0b) ##1 !req.wr |=> sleep_clock_divider == 8'h01 << slp[6:4])
    else $error("sleep divider not two to the code");
  a_release_bound: assert property (
    arel[3] && arel[2:0] == 3'h0 |-> low_cnt <= 3 * TICK_CYC)
    else $error("interrupt not auto released");
  a_sense_follow: assert property (
    (!sleep_active) [*3] |-> key_sense_on == $past(chen))
    else $error("channel sense enable mismatch");
endmodule
bind tkeis_core tkeis_monitor #(.KEYS(KEYS), .COUNT_W(COUNT_W),
  .TICK_CYC(TICK_CYC)) u_tkeis_monitor (.clk, .rst_n, .req, .rdata,
  .raw_count, .raw_valid, .interrupt_output_n, .key_sense_on, .recal_pulse,
  .key_delta_count, .key_delta_valid, .sleep_active, .sleep_clock_divider);
`default_nettype wire
